/* File: rtl/sis_pkg.sv */
// Purpose: shared constants for the digital audio input selector
// Assumes: 8-bit register port, 4-bit byte address
// Notes:   every offset, field position, reset value and count lives here
package sis_pkg;

  localparam int unsigned SIS_AW = 4;
  localparam int unsigned SIS_DW = 8;

  // register byte addresses
  localparam logic [3:0] SIS_ADDR_CTRL = 4'h0;
  localparam logic [3:0] SIS_ADDR_STAT = 4'h4;

  // control register fields
  localparam int unsigned SIS_CTRL_RXSEL  = 0;
  localparam int unsigned SIS_CTRL_MULTI_PIN_FUNCTION_SELECT  = 1;
  localparam int unsigned SIS_CTRL_THROUGH_OUTPUT_SELECT = 3;
  localparam int unsigned SIS_CTRL_GENERAL_OUTPUT_SELECT = 4;
  localparam int unsigned SIS_CTRL_NPMUTE = 6;
  localparam logic [7:0]  SIS_CTRL_RST    = 8'h00;
  localparam logic [7:0]  SIS_CTRL_MASK   = 8'h7f;

  // status register fields
  localparam int unsigned SIS_STAT_NONPCM = 0;
  localparam int unsigned SIS_STAT_EMPH   = 1;
  localparam int unsigned SIS_STAT_MUTE   = 2;
  localparam int unsigned SIS_STAT_HOST   = 3;

  // multi-purpose pin function
  typedef enum logic [1:0] {
    SIS_MP_HIZ      = 2'b00,
    SIS_MP_SPDIF_IN = 2'b01,
    SIS_MP_RSVD_2   = 2'b10,
    SIS_MP_RSVD_3   = 2'b11
  } sis_mp_mode_t;

  // general output pin content
  typedef enum logic [1:0] {
    SIS_GPO_LOW    = 2'b00,
    SIS_GPO_THRU   = 2'b01,
    SIS_GPO_SW_A   = 2'b10,
    SIS_GPO_SW_B   = 2'b11
  } sis_gpo_mode_t;

  // channel status bit positions on cs_bits_in
  localparam int unsigned SIS_CS_PRO    = 0;
  localparam int unsigned SIS_CS_NONPCM = 1;
  localparam int unsigned SIS_CS_EMPH   = 3;
  localparam logic [2:0]  SIS_CS_EMPH_5015 = 3'h1;

  // dedicated-pin flags refresh once per channel status block
  localparam logic [7:0] SIS_BLOCK_LAST = 8'hbf;

  // cycles after reset until the three-flop strap filter shows the real pin level
  localparam logic [2:0] SIS_SYNC_FLUSH = 3'h4;

endpackage

/* File: rtl/sis_sync.sv */
// Purpose: three-flop synchroniser with agreement filter for a pin input
// Assumes: input is asynchronous to clk_sys_in
// Notes:   output changes only once stages two and three agree
`timescale 1ns/10ps
module sis_sync (
  input  wire logic clk_sys_in,
  input  wire logic sys_rst_in,
  input  wire logic async_in,
  output logic      sync_out
);

  logic s1_q, s2_q, s3_q, f_q;
  logic f_d;

  always_comb begin
    f_d = f_q;
    if (s2_q == s3_q) begin
      f_d = s3_q;
    end
  end

  // first stage feeds only the second
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      f_q  <= 1'b0;
    end else begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      f_q  <= f_d;
    end
  end

  assign sync_out = f_q;

endmodule

/* File: rtl/sis_selector.sv */
// Purpose: input and output selector around a digital audio receiver
// Assumes: demodulator, channel status and serial audio on clk_sys_in
// Notes:   pins are filtered through sis_sync; all outputs are flops
`timescale 1ns/10ps
module sis_selector (
  input  wire logic       clk_sys_in,
  input  wire logic       sys_rst_in,
  input  wire logic [3:0] reg_addr_in,
  input  wire logic [7:0] reg_wdata_in,
  input  wire logic       reg_wr_in,
  input  wire logic       reg_rd_in,
  output logic      [7:0] reg_rdata_out,
  input  wire logic       host_strap_in,
  input  wire logic       primary_receive_pin_in,
  input  wire logic       multi_purpose_pin_in,
  output logic            multi_purpose_pin_out,
  output logic            multi_purpose_pin_oe_out,
  output logic            general_output_pin_out,
  output logic            demod_data_out,
  input  wire logic       frame_strobe_in,
  input  wire logic [5:0] cs_bits_in,
  input  wire logic       serial_audio_in,
  output logic            serial_audio_out
);

  logic rx_f, mp_f, host_f;

  sis_sync u_sync_rx (
    .clk_sys_in (clk_sys_in),
    .sys_rst_in (sys_rst_in),
    .async_in   (primary_receive_pin_in),
    .sync_out   (rx_f)
  );

  sis_sync u_sync_mp (
    .clk_sys_in (clk_sys_in),
    .sys_rst_in (sys_rst_in),
    .async_in   (multi_purpose_pin_in),
    .sync_out   (mp_f)
  );

  // strap is watched continuously, so a host can be attached late
  sis_sync u_sync_host (
    .clk_sys_in (clk_sys_in),
    .sys_rst_in (sys_rst_in),
    .async_in   (host_strap_in),
    .sync_out   (host_f)
  );

  // ---------------- strap settle ----------------
  // host_f shows its reset value until the filter has flushed; driving the
  // multi pin on that guess would fight a host-mode input right after reset
  logic [2:0] settle_q, settle_d;
  logic       strap_ok;

  always_comb begin
    settle_d = settle_q;
    if (settle_q != sis_pkg::SIS_SYNC_FLUSH) begin
      settle_d = settle_q + 3'h1;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      settle_q <= 3'h0;
    end else begin
      settle_q <= settle_d;
    end
  end

  assign strap_ok = (settle_q == sis_pkg::SIS_SYNC_FLUSH);

  // ---------------- register port ----------------
  logic [7:0] ctrl_q, ctrl_d;
  logic [7:0] rdata_q, rdata_d;
  logic [7:0] stat;

  sis_pkg::sis_mp_mode_t  multi_pin_function_select;
  sis_pkg::sis_gpo_mode_t general_output_select;
  logic                   rxsel, through_output_select, npmute;

  assign multi_pin_function_select  = sis_pkg::sis_mp_mode_t'(ctrl_q[sis_pkg::SIS_CTRL_MULTI_PIN_FUNCTION_SELECT +: 2]);
  assign general_output_select = sis_pkg::sis_gpo_mode_t'(ctrl_q[sis_pkg::SIS_CTRL_GENERAL_OUTPUT_SELECT +: 2]);
  assign rxsel  = ctrl_q[sis_pkg::SIS_CTRL_RXSEL];
  assign through_output_select = ctrl_q[sis_pkg::SIS_CTRL_THROUGH_OUTPUT_SELECT];
  assign npmute = ctrl_q[sis_pkg::SIS_CTRL_NPMUTE];

  logic nonpcm_q, emph_q, mute_q;

  always_comb begin
    stat = 8'h00;
    stat[sis_pkg::SIS_STAT_NONPCM] = nonpcm_q;
    stat[sis_pkg::SIS_STAT_EMPH]   = emph_q;
    stat[sis_pkg::SIS_STAT_MUTE]   = mute_q;
    stat[sis_pkg::SIS_STAT_HOST]   = host_f;
  end

  always_comb begin
    ctrl_d  = ctrl_q;
    rdata_d = 8'h00;
    if (reg_wr_in && reg_addr_in == sis_pkg::SIS_ADDR_CTRL) begin
      ctrl_d = reg_wdata_in & sis_pkg::SIS_CTRL_MASK;
    end
    if (reg_rd_in) begin
      case (reg_addr_in)
        sis_pkg::SIS_ADDR_CTRL: rdata_d = ctrl_q;
        sis_pkg::SIS_ADDR_STAT: rdata_d = stat;
        default:                rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      ctrl_q  <= sis_pkg::SIS_CTRL_RST;
      rdata_q <= 8'h00;
    end else begin
      ctrl_q  <= ctrl_d;
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata_out = rdata_q;

  // ---------------- channel status flags ----------------
  logic [7:0] frame_cnt_q, frame_cnt_d;
  logic       nonpcm_d, emph_d;

  always_comb begin
    frame_cnt_d = frame_cnt_q;
    nonpcm_d    = nonpcm_q;
    emph_d      = emph_q;
    if (frame_strobe_in) begin
      if (frame_cnt_q == sis_pkg::SIS_BLOCK_LAST) begin
        frame_cnt_d = 8'h00;
        nonpcm_d    = cs_bits_in[sis_pkg::SIS_CS_NONPCM];
        emph_d      = !cs_bits_in[sis_pkg::SIS_CS_PRO] && !cs_bits_in[sis_pkg::SIS_CS_NONPCM]
                      && cs_bits_in[sis_pkg::SIS_CS_EMPH +: 3] == sis_pkg::SIS_CS_EMPH_5015;
      end else begin
        frame_cnt_d = frame_cnt_q + 8'h01;
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      frame_cnt_q <= 8'h00;
      nonpcm_q    <= 1'b0;
      emph_q      <= 1'b0;
    end else begin
      frame_cnt_q <= frame_cnt_d;
      nonpcm_q    <= nonpcm_d;
      emph_q      <= emph_d;
    end
  end

  // ---------------- routing ----------------
  logic mp_in_en, mp_src, thru_src;
  logic demod_q, demod_d, gpo_q, gpo_d, mp_out_q, mp_out_d, mp_oe_q, mp_oe_d;
  logic audio_q, audio_d, mute_d;

  always_comb begin
    // functions other than SIS_MP_SPDIF_IN disconnect the multi pin input; mp_src stays low
    mp_in_en = host_f && multi_pin_function_select == sis_pkg::SIS_MP_SPDIF_IN;
    mp_src   = mp_in_en ? mp_f : 1'b0;
    thru_src = through_output_select ? mp_src : rx_f;
    demod_d  = (host_f && rxsel) ? mp_src : rx_f;
    gpo_d    = 1'b0;
    if (!host_f) begin
      gpo_d = nonpcm_q;
    end else begin
      case (general_output_select)
        sis_pkg::SIS_GPO_THRU: gpo_d = thru_src;
        sis_pkg::SIS_GPO_SW_A: gpo_d = 1'b0;
        sis_pkg::SIS_GPO_SW_B: gpo_d = 1'b1;
        default:               gpo_d = 1'b0;
      endcase
    end
    // the pin is only driven without a host, so it never fights an input
    mp_oe_d  = strap_ok && !host_f;
    mp_out_d = !emph_q;
    mute_d   = host_f && npmute && nonpcm_q;
    audio_d  = mute_d ? 1'b0 : serial_audio_in;
  end

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      demod_q  <= 1'b0;
      gpo_q    <= 1'b0;
      mp_out_q <= 1'b0;
      mp_oe_q  <= 1'b0;
      mute_q   <= 1'b0;
      audio_q  <= 1'b0;
    end else begin
      demod_q  <= demod_d;
      gpo_q    <= gpo_d;
      mp_out_q <= mp_out_d;
      mp_oe_q  <= mp_oe_d;
      mute_q   <= mute_d;
      audio_q  <= audio_d;
    end
  end

  assign demod_data_out           = demod_q;
  assign general_output_pin_out   = gpo_q;
  assign multi_purpose_pin_out    = mp_out_q;
  assign multi_purpose_pin_oe_out = mp_oe_q;
  assign serial_audio_out         = audio_q;

  // ---------------- checks ----------------
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (sys_rst_in);

  a_reset_ctrl_default: assert property ($past(sys_rst_in) |-> ctrl_q == sis_pkg::SIS_CTRL_RST && !mp_oe_q)
    else $error("control not at reset value after reset");

  a_mp_input_undriven: assert property (mp_in_en |=> !multi_purpose_pin_oe_out)
    else $error("multi pin driven while used as input");

  a_demod_primary_src: assert property ((!host_f || !rxsel) |=> demod_data_out == $past(rx_f))
    else $error("demodulator not fed by primary pin");

  a_demod_multi_src: assert property ((host_f && rxsel && mp_in_en) |=> demod_data_out == $past(mp_f))
    else $error("demodulator not fed by multi pin");

  a_gpo_switch_level: assert property ((host_f && general_output_select[1]) |=> general_output_pin_out == $past(general_output_select[0]))
    else $error("switch level does not follow general select");

  a_gpo_thru_copy: assert property ((host_f && general_output_select == sis_pkg::SIS_GPO_THRU)
                                    |=> general_output_pin_out == $past(thru_src))
    else $error("through copy wrong on output pin");

  a_gpo_low_idle: assert property ((host_f && general_output_select == sis_pkg::SIS_GPO_LOW) |=> !general_output_pin_out)
    else $error("output pin not low with general select clear");

  a_nohost_gpo_flag: assert property (!host_f |=> general_output_pin_out == $past(nonpcm_q))
    else $error("output pin does not carry non-PCM flag");

  a_nohost_emph_pin: assert property ((!host_f && strap_ok) |=> multi_purpose_pin_oe_out
                                      && multi_purpose_pin_out == !$past(emph_q))
    else $error("emphasis flag wrong on multi pin");

  a_mp_hiz_settle: assert property (!strap_ok |=> !multi_purpose_pin_oe_out)
    else $error("multi pin driven before strap settled");

  a_demod_multi_off: assert property ((host_f && rxsel && !mp_in_en) |=> !demod_data_out)
    else $error("demodulator fed by multi pin while not an input");

  a_nonpcm_mute: assert property ((host_f && npmute && nonpcm_q) |=> !serial_audio_out && mute_q)
    else $error("audio not muted on non-PCM");

  a_audio_pass: assert property (!(host_f && npmute && nonpcm_q)
                                 |=> serial_audio_out == $past(serial_audio_in))
    else $error("audio muted without cause");

  a_flag_hold_block: assert property ((!frame_strobe_in || frame_cnt_q != sis_pkg::SIS_BLOCK_LAST)
                                      |=> $stable(nonpcm_q) && $stable(emph_q))
    else $error("flags changed inside a block");

  a_flag_refresh: assert property ((frame_strobe_in && frame_cnt_q == sis_pkg::SIS_BLOCK_LAST)
                                   |=> nonpcm_q == $past(cs_bits_in[sis_pkg::SIS_CS_NONPCM]))
    else $error("non-PCM flag not taken at block end");

  a_frame_cnt_range: assert property (frame_cnt_q <= sis_pkg::SIS_BLOCK_LAST)
    else $error("frame counter beyond block end");

  a_ctrl_write: assert property ((reg_wr_in && reg_addr_in == sis_pkg::SIS_ADDR_CTRL)
                                 |=> ctrl_q == ($past(reg_wdata_in) & sis_pkg::SIS_CTRL_MASK))
    else $error("control write not taken");

  a_stat_read: assert property ((reg_rd_in && reg_addr_in == sis_pkg::SIS_ADDR_STAT)
                                |=> reg_rdata_out == $past(stat))
    else $error("status read data wrong");

  a_rdata_one_cycle: assert property (!reg_rd_in |=> reg_rdata_out == 8'h00)
    else $error("read data stood without a read");

  c_block_refresh: cover property (frame_strobe_in && frame_cnt_q == sis_pkg::SIS_BLOCK_LAST);
  c_multi_demod:   cover property (host_f && rxsel && mp_in_en);
  c_mute_active:   cover property (mute_q);
  c_switch_b:      cover property (host_f && general_output_select == sis_pkg::SIS_GPO_SW_B);
  c_nohost_drive:  cover property (strap_ok && !host_f && multi_purpose_pin_oe_out);

endmodule

/* File: dv/sis_src_model.sv */
// Purpose: far side of the selector: channel status frame strobes and the pulled-up multi pin
// Assumes: bench sets pin levels and starts a burst of frames with a one-cycle go pulse
// Notes:   an undriven multi pin floats high through its pull-up, never keeps a stale level
`timescale 1ns/10ps
module sis_src_model (
  input  wire logic       clk_sys_in,
  input  wire logic       mp_drive_in,
  input  wire logic       mp_lvl_in,
  input  wire logic       dut_mp_in,
  input  wire logic       dut_oe_in,
  input  wire logic [8:0] frames_in,
  input  wire logic       go_in,
  output logic            mp_pin_out,
  output logic            strobe_out
);
  logic [9:0] cnt_q = 10'h000;
  // pull-up wins when nobody drives
  assign mp_pin_out = dut_oe_in ? dut_mp_in : (mp_drive_in ? mp_lvl_in : 1'b1);
  // one strobe every second cycle, exactly frames_in of them
  assign strobe_out = cnt_q[0];
  always @(posedge clk_sys_in) begin
    if (go_in)
      cnt_q <= {frames_in, 1'b0};
    else if (cnt_q != 10'h000)
      cnt_q <= cnt_q - 10'h001;
  end
endmodule

/* File: dv/test_spdif_input_selector.sv */
// Purpose: self-checking bench for the audio input selector
// Assumes: host register port, pins filtered by three flops
// Notes:   pins settle for 8 cycles before each routing check
`timescale 1ns/10ps
module test_spdif_input_selector;
  logic        clk_sys_in = 1'b0;
  logic        sys_rst_in = 1'b1;
  logic [3:0]  addr       = 4'h0;
  logic [7:0]  wdata      = 8'h00;
  logic        wr         = 1'b0;
  logic        rd         = 1'b0;
  logic        host       = 1'b1;
  logic        prim       = 1'b0;
  logic        mp_drv     = 1'b1;
  logic        mp_lvl     = 1'b0;
  logic        go         = 1'b0;
  logic        sa_in      = 1'b1;
  logic [5:0]  cs         = 6'h00;
  logic [8:0]  frames     = 9'h000;
  logic [7:0]  rdata;
  logic [7:0]  rv;
  logic [31:0] r;
  logic        mp_out;
  logic        mp_oe;
  logic        mp_pin;
  logic        general_output_pin;
  logic        demod;
  logic        strobe;
  logic        sa_out;
  int          miscompares = 0;
  int          compares    = 0;
  int          cycles      = 0;

  always #12.5 clk_sys_in = ~clk_sys_in;

  sis_selector u_dut (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .host_strap_in(host),
    .primary_receive_pin_in(prim), .multi_purpose_pin_in(mp_pin), .multi_purpose_pin_out(mp_out),
    .multi_purpose_pin_oe_out(mp_oe), .general_output_pin_out(general_output_pin), .demod_data_out(demod),
    .frame_strobe_in(strobe), .cs_bits_in(cs), .serial_audio_in(sa_in), .serial_audio_out(sa_out));

  sis_src_model u_src (.clk_sys_in(clk_sys_in), .mp_drive_in(mp_drv), .mp_lvl_in(mp_lvl),
    .dut_mp_in(mp_out), .dut_oe_in(mp_oe), .frames_in(frames), .go_in(go), .mp_pin_out(mp_pin),
    .strobe_out(strobe));

  task automatic results;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys_in);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk_sys_in);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [3:0] a, output logic [7:0] v);
    @(posedge clk_sys_in);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk_sys_in);
    rd <= 1'b0;
    #1 v = rdata;
  endtask

  // runs n frame strobes with channel status c, then lets flags and pins land
  task automatic blocks(input logic [8:0] n, input logic [5:0] c);
    @(posedge clk_sys_in);
    cs <= c;
    frames <= n;
    go <= 1'b1;
    @(posedge clk_sys_in);
    go <= 1'b0;
    repeat (2 * n + 4) @(posedge clk_sys_in);
  endtask

  // {general pin, demodulator input, multi pin enable} in host mode
  function automatic logic [2:0] route(input logic [6:0] c, input logic p, input logic m);
    logic ms;
    logic g;
    ms = (c[2:1] == 2'b01) & m;
    case (c[5:4])
      2'b00:   g = 1'b0;
      2'b01:   g = c[3] ? ms : p;
      default: g = c[4];
    endcase
    return {g, c[0] ? ms : p, 1'b0};
  endfunction

  always @(posedge clk_sys_in) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      results();
    end
  end

  initial begin
    r = $urandom(40);
    repeat (8) @(posedge clk_sys_in);
    sys_rst_in <= 1'b0;
    #1 chk({5'h00, general_output_pin, demod, mp_oe}, 8'h00);
    rd_reg(4'h0, rv);
    chk(rv, 8'h00);
    for (int i = 0; i < 128; i++) begin
      r = $urandom;
      @(posedge clk_sys_in);
      prim <= r[0];
      mp_lvl <= r[1];
      wr_reg(4'h0, i[7:0]);
      repeat (8) @(posedge clk_sys_in);
      #1 chk({5'h00, general_output_pin, demod, mp_oe}, {5'h00, route(i[6:0], r[0], r[1])});
    end
    wr_reg(4'h4, 8'hff);
    rd_reg(4'h0, rv);
    chk(rv, 8'h7f);
    rd_reg(4'h8, rv);
    chk(rv, 8'h00);
    // mid-run reset with a host attached: the multi pin must never be driven
    @(posedge clk_sys_in);
    sys_rst_in <= 1'b1;
    repeat (8) @(posedge clk_sys_in);
    sys_rst_in <= 1'b0;
    repeat (8) begin
      @(posedge clk_sys_in);
      #1 chk({7'h00, mp_oe}, 8'h00);
    end
    rd_reg(4'h0, rv);
    chk(rv, 8'h00);
    wr_reg(4'h0, 8'h40);
    blocks(9'd191, 6'h02);
    rd_reg(4'h4, rv);
    chk(rv, 8'h08);
    chk({7'h00, sa_out}, 8'h01);
    blocks(9'd1, 6'h02);
    rd_reg(4'h4, rv);
    chk(rv, 8'h0d);
    chk({6'h00, sa_out, general_output_pin}, 8'h00);
    blocks(9'd192, 6'h08);
    rd_reg(4'h4, rv);
    chk(rv, 8'h0a);
    chk({7'h00, sa_out}, 8'h01);
    @(posedge clk_sys_in);
    mp_drv <= 1'b0;
    host <= 1'b0;
    wr_reg(4'h0, 8'h31);
    prim <= 1'b1;
    repeat (12) @(posedge clk_sys_in);
    #1 chk({4'h0, mp_oe, mp_pin, general_output_pin, demod}, 8'h09);
    blocks(9'd192, 6'h02);
    #1 chk({4'h0, mp_oe, mp_pin, general_output_pin, sa_out}, 8'h0f);
    results();
  end
endmodule
